//--- shared/tmctl_pkg.sv
// package: register map, field layout and encodings of the 16-bit timer control block
package tmctl_pkg;
  // data-space and I/O byte addresses, and the control register reset value
  localparam logic [7:0] TMCTL_IO_DATA_OFS = 8'h20;
  localparam logic [7:0] TMCTL_EXT_BASE = 8'h60;
  localparam logic [7:0] TMCTL_T1_CTRL_A_IO = 8'h2F;
  localparam logic [7:0] TMCTL_T1_CTRL_B_IO = 8'h2E;
  localparam logic [7:0] TMCTL_T3_CTRL_A_ADR = 8'h8B;
  localparam logic [7:0] TMCTL_T3_CTRL_B_ADR = 8'h8A;
  localparam logic [7:0] TMCTL_CTRL_RESET = 8'h00;
  // control register B fields
  localparam int TMCTL_B_NOISE_BIT = 7;
  localparam int TMCTL_B_EDGE_BIT = 6;
  localparam int TMCTL_B_UNUSED_BIT = 5;
  localparam int TMCTL_B_WGM_HI = 4;
  localparam int TMCTL_B_WGM_LO = 3;
  localparam logic [7:0] TMCTL_B_WMASK = 8'hDF;
  // TOP and BOTTOM constants, and the capture noise filter length
  localparam logic [15:0] TMCTL_MAX = 16'hFFFF;
  localparam logic [15:0] TMCTL_TOP8 = 16'h00FF;
  localparam logic [15:0] TMCTL_TOP9 = 16'h01FF;
  localparam logic [15:0] TMCTL_TOP10 = 16'h03FF;
  localparam logic [15:0] TMCTL_BOTTOM = 16'h0000;
  localparam logic [2:0] TMCTL_FILTER_LEN = 3'h4;
  // prescaler taps
  localparam logic [9:0] TMCTL_DIV8_MASK = 10'h007;
  localparam logic [9:0] TMCTL_DIV64_MASK = 10'h03F;
  localparam logic [9:0] TMCTL_DIV256_MASK = 10'h0FF;
  localparam logic [9:0] TMCTL_DIV1024_MASK = 10'h3FF;

  typedef enum logic [2:0] {
    TMCTL_CS_STOP = 3'b000,
    TMCTL_CS_DIV1 = 3'b001,
    TMCTL_CS_DIV8 = 3'b010,
    TMCTL_CS_DIV64 = 3'b011,
    TMCTL_CS_DIV256 = 3'b100,
    TMCTL_CS_DIV1024 = 3'b101,
    TMCTL_CS_EXT_FALL = 3'b110,
    TMCTL_CS_EXT_RISE = 3'b111
  } tmctl_cs_t;

  typedef enum logic [1:0] {
    TMCTL_TOP_FIXED = 2'b00,
    TMCTL_TOP_CMPA = 2'b01,
    TMCTL_TOP_CAPT = 2'b10
  } tmctl_topsrc_t;

  typedef enum logic [1:0] {
    TMCTL_EV_IMMEDIATE = 2'b00,
    TMCTL_EV_TOP = 2'b01,
    TMCTL_EV_BOTTOM = 2'b10,
    TMCTL_EV_MAX = 2'b11
  } tmctl_ev_t;
endpackage

//--- logic/tmctl_timer16.sv
// module: one 16-bit timer's mode, clock select and capture control with its counter core
`timescale 1ns/10ps
module tmctl_timer16
  import tmctl_pkg::*;
#(
  parameter logic [7:0] CTRL_A_ADR = 8'h4F,
  parameter logic [7:0] CTRL_B_ADR = 8'h4E,
  parameter logic [15:0] CMPA_RESET = 16'h0000
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] dat_addr,
  input wire logic dat_wr,
  input wire logic dat_rd,
  input wire logic [7:0] dat_wdata,
  output logic [7:0] dat_rdata,
  input wire logic [15:0] compare_a_wdata,
  input wire logic compare_a_wr,
  input wire logic capture_pin,
  input wire logic ext_count_pin,
  input wire logic capture_flag_clr,
  output logic [15:0] count_q,
  output logic [15:0] compare_a_value,
  output logic [15:0] capture_value,
  output logic capture_flag,
  output logic overflow_flag,
  output logic count_down
);
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [3:0] waveform_mode_sel;
  tmctl_cs_t clock_source_sel;
  logic capture_noise_filter_en;
  logic capture_edge_sel;
  logic [9:0] presc_q;
  logic ext_q;
  logic tick;
  logic [1:0] filt_cnt_q;
  logic filt_out_q;
  logic cap_raw_q;
  logic cap_in;
  logic cap_prev_q;
  logic cap_event;
  logic [15:0] cmpa_buf_q;
  logic [15:0] top_val;
  tmctl_topsrc_t top_src;
  tmctl_ev_t upd_ev;
  tmctl_ev_t ovf_ev;
  logic dual_slope;
  logic at_top;
  logic at_bottom;
  logic at_max;
  logic cap_disabled;

  function automatic logic ev_hit(input tmctl_ev_t ev, input logic top_hit,
                                  input logic bot_hit, input logic max_hit);
    unique case (ev)
      TMCTL_EV_IMMEDIATE: ev_hit = 1'b1;
      TMCTL_EV_TOP: ev_hit = top_hit;
      TMCTL_EV_BOTTOM: ev_hit = bot_hit;
      TMCTL_EV_MAX: ev_hit = max_hit;
    endcase
  endfunction

  // registers: low I/O ones sit at their I/O offset plus the data-space offset
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_a_q <= TMCTL_CTRL_RESET;
      ctrl_b_q <= TMCTL_CTRL_RESET;
    end else if (dat_wr) begin
      if (dat_addr == CTRL_A_ADR) begin
        ctrl_a_q <= dat_wdata;
      end
      if (dat_addr == CTRL_B_ADR) begin
        ctrl_b_q <= dat_wdata & TMCTL_B_WMASK;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dat_rdata <= 8'h00;
    end else if (dat_rd) begin
      if (dat_addr == CTRL_A_ADR) begin
        dat_rdata <= ctrl_a_q;
      end else if (dat_addr == CTRL_B_ADR) begin
        dat_rdata <= ctrl_b_q & TMCTL_B_WMASK;
      end else begin
        dat_rdata <= 8'h00;
      end
    end
  end

  assign waveform_mode_sel = {ctrl_b_q[TMCTL_B_WGM_HI], ctrl_b_q[TMCTL_B_WGM_LO],
                              ctrl_a_q[1:0]};
  assign clock_source_sel = tmctl_cs_t'(ctrl_b_q[2:0]);
  assign capture_noise_filter_en = ctrl_b_q[TMCTL_B_NOISE_BIT];
  assign capture_edge_sel = ctrl_b_q[TMCTL_B_EDGE_BIT];

  // mode decode; mode 13 falls to normal counting since software must not use it
  always_comb begin
    top_src = TMCTL_TOP_FIXED;
    top_val = TMCTL_MAX;
    upd_ev = TMCTL_EV_IMMEDIATE;
    ovf_ev = TMCTL_EV_MAX;
    dual_slope = 1'b0;
    unique case (waveform_mode_sel)
      4'h0: begin
        top_val = TMCTL_MAX;
      end
      4'h1, 4'h2, 4'h3: begin
        top_val = (waveform_mode_sel == 4'h1) ? TMCTL_TOP8 :
                  (waveform_mode_sel == 4'h2) ? TMCTL_TOP9 : TMCTL_TOP10;
        upd_ev = TMCTL_EV_TOP;
        ovf_ev = TMCTL_EV_BOTTOM;
        dual_slope = 1'b1;
      end
      4'h4: top_src = TMCTL_TOP_CMPA;
      4'h5, 4'h6, 4'h7: begin
        top_val = (waveform_mode_sel == 4'h5) ? TMCTL_TOP8 :
                  (waveform_mode_sel == 4'h6) ? TMCTL_TOP9 : TMCTL_TOP10;
        upd_ev = TMCTL_EV_BOTTOM;
        ovf_ev = TMCTL_EV_TOP;
      end
      4'h8, 4'h9: begin
        top_src = (waveform_mode_sel == 4'h8) ? TMCTL_TOP_CAPT : TMCTL_TOP_CMPA;
        upd_ev = TMCTL_EV_BOTTOM;
        ovf_ev = TMCTL_EV_BOTTOM;
        dual_slope = 1'b1;
      end
      4'hA, 4'hB: begin
        top_src = (waveform_mode_sel == 4'hA) ? TMCTL_TOP_CAPT : TMCTL_TOP_CMPA;
        upd_ev = TMCTL_EV_TOP;
        ovf_ev = TMCTL_EV_BOTTOM;
        dual_slope = 1'b1;
      end
      4'hC: top_src = TMCTL_TOP_CAPT;
      4'hD: top_val = TMCTL_MAX;
      4'hE, 4'hF: begin
        top_src = (waveform_mode_sel == 4'hE) ? TMCTL_TOP_CAPT : TMCTL_TOP_CMPA;
        upd_ev = TMCTL_EV_BOTTOM;
        ovf_ev = TMCTL_EV_TOP;
      end
    endcase
    if (top_src == TMCTL_TOP_CMPA) begin
      top_val = compare_a_value;
    end else if (top_src == TMCTL_TOP_CAPT) begin
      top_val = capture_value;
    end
  end

  // prescaler runs free; each tap gives one-cycle enables
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      presc_q <= 10'h000;
    end else begin
      presc_q <= presc_q + 10'h001;
    end
  end

  // pin sampled regardless of its port direction
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_count_pin;
    end
  end

  always_comb begin
    unique case (clock_source_sel)
      TMCTL_CS_STOP: tick = 1'b0;
      TMCTL_CS_DIV1: tick = 1'b1;
      TMCTL_CS_DIV8: tick = (presc_q & TMCTL_DIV8_MASK) == TMCTL_DIV8_MASK;
      TMCTL_CS_DIV64: tick = (presc_q & TMCTL_DIV64_MASK) == TMCTL_DIV64_MASK;
      TMCTL_CS_DIV256: tick = (presc_q & TMCTL_DIV256_MASK) == TMCTL_DIV256_MASK;
      TMCTL_CS_DIV1024: tick = presc_q == TMCTL_DIV1024_MASK;
      TMCTL_CS_EXT_FALL: tick = ext_q & ~ext_count_pin;
      TMCTL_CS_EXT_RISE: tick = ~ext_q & ext_count_pin;
    endcase
  end

  assign at_top = count_q == top_val;
  assign at_bottom = count_q == TMCTL_BOTTOM;
  assign at_max = count_q == TMCTL_MAX;

  // counter: single slope wraps at TOP, dual slope turns round at TOP and BOTTOM
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      count_q <= 16'h0000;
      count_down <= 1'b0;
    end else if (tick) begin
      if (!dual_slope) begin
        count_down <= 1'b0;
        count_q <= at_top ? TMCTL_BOTTOM : count_q + 16'h0001;
      end else if (count_down) begin
        count_down <= !(count_q == 16'h0001);
        count_q <= at_bottom ? 16'h0001 : count_q - 16'h0001;
      end else begin
        count_down <= (count_q + 16'h0001 >= top_val);
        count_q <= at_top ? count_q - 16'h0001 : count_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      overflow_flag <= 1'b0;
    end else if (tick && ev_hit(ovf_ev, at_top, at_bottom, at_max)) begin
      overflow_flag <= 1'b1;
    end else if (capture_flag_clr) begin
      overflow_flag <= 1'b0;
    end
  end

  // double buffer for compare A: the buffer is loaded by software, copied at the update point
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cmpa_buf_q <= CMPA_RESET;
    end else if (compare_a_wr) begin
      cmpa_buf_q <= compare_a_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      compare_a_value <= CMPA_RESET;
    end else if (upd_ev == TMCTL_EV_IMMEDIATE) begin
      if (compare_a_wr) begin
        compare_a_value <= compare_a_wdata;
      end
    end else if (tick && ev_hit(upd_ev, at_top, at_bottom, at_max)) begin
      compare_a_value <= cmpa_buf_q;
    end
  end

  // noise filter costs four cycles of latency on every capture
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cap_raw_q <= 1'b0;
      filt_cnt_q <= 2'b00;
      filt_out_q <= 1'b0;
    end else begin
      cap_raw_q <= capture_pin;
      if (cap_raw_q == filt_out_q) begin
        filt_cnt_q <= 2'b00;
      end else if ({1'b0, filt_cnt_q} == TMCTL_FILTER_LEN - 3'h1) begin
        filt_out_q <= cap_raw_q;
        filt_cnt_q <= 2'b00;
      end else begin
        filt_cnt_q <= filt_cnt_q + 2'b01;
      end
    end
  end

  assign cap_in = capture_noise_filter_en ? filt_out_q : cap_raw_q;
  assign cap_disabled = (top_src == TMCTL_TOP_CAPT);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cap_prev_q <= 1'b0;
    end else begin
      cap_prev_q <= cap_in;
    end
  end

  assign cap_event = !cap_disabled &&
                     (capture_edge_sel ? (cap_in & ~cap_prev_q) : (~cap_in & cap_prev_q));

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      capture_value <= 16'h0000;
    end else if (cap_event) begin
      capture_value <= count_q;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      capture_flag <= 1'b0;
    end else if (cap_event) begin
      capture_flag <= 1'b1;
    end else if (capture_flag_clr) begin
      capture_flag <= 1'b0;
    end
  end
endmodule

//--- test/tmctl_timer16_monitor.sv
// checker: port-level properties of the timer control block
`timescale 1ns/10ps
module tmctl_timer16_monitor
  import tmctl_pkg::*;
#(
  parameter logic [7:0] CTRL_A_ADR = 8'h4F,
  parameter logic [7:0] CTRL_B_ADR = 8'h4E
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] dat_addr,
  input wire logic dat_wr,
  input wire logic dat_rd,
  input wire logic [7:0] dat_wdata,
  input wire logic [7:0] dat_rdata,
  input wire logic [15:0] compare_a_wdata,
  input wire logic compare_a_wr,
  input wire logic capture_pin,
  input wire logic [15:0] count_q,
  input wire logic [15:0] compare_a_value,
  input wire logic capture_flag,
  input wire logic overflow_flag
);
  logic [7:0] a_q;
  logic [7:0] b_q;
  logic [3:0] mode;
  logic cap_on;
  logic run1;
  // shadow copies of the control bytes, since only the bus is visible here
  assign mode = {b_q[4:3], a_q[1:0]};
  assign cap_on = !(mode[3] && !mode[0]);
  assign run1 = b_q[2:0] == 3'b001;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) a_q <= 8'h00;
    else if (dat_wr && dat_addr == CTRL_A_ADR) a_q <= dat_wdata;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) b_q <= 8'h00;
    else if (dat_wr && dat_addr == CTRL_B_ADR) b_q <= dat_wdata;
  end
  a_bit5_zero: assert property (
    dat_rd && dat_addr == CTRL_B_ADR |=> !dat_rdata[5]) else $error("reg B bit 5 set");
  // a control write takes effect on its own edge, so the next tick follows the new select
  a_stop_holds: assert property (
    b_q[2:0] == 3'b000 && !dat_wr |=> $stable(count_q)) else $error("stopped counter moved");
  a_div1_step: assert property (
    mode == 4'h0 && run1 && !dat_wr |=> count_q == $past(count_q) + 16'h0001)
    else $error("no step");
  a_capt_edge: assert property (
    cap_on && !b_q[7] && (b_q[6] ? $rose(capture_pin) : $fell(capture_pin))
    |-> ##[1:2] capture_flag) else $error("capture missed");
  a_filter_wait: assert property (
    cap_on && b_q[7] && b_q[6] && $rose(capture_pin) && !capture_flag
    |-> !capture_flag[*5] ##[0:2] capture_flag) else $error("filter delay wrong");
  a_capt_off: assert property (
    !cap_on && !dat_wr |=> !$rose(capture_flag)) else $error("capture while disabled");
  a_cmp_now: assert property (
    compare_a_wr && (mode == 4'h0 || mode == 4'h4 || mode == 4'hC)
    |=> compare_a_value == $past(compare_a_wdata)) else $error("compare not immediate");
  a_cmp_held: assert property (
    compare_a_wr && mode == 4'h1 && count_q != 16'h00FF && count_q != 16'h0000
    |=> $stable(compare_a_value)) else $error("compare loaded early");
  a_fast_top: assert property (
    mode == 4'h5 && run1 && count_q == 16'h00FF
    |=> overflow_flag && count_q == 16'h0000) else $error("fast top wrong");
  a_pc_top: assert property (
    mode == 4'h1 && run1 && count_q == 16'h00FF && !overflow_flag
    |=> !overflow_flag && count_q < 16'h00FF) else $error("phase top wrong");
endmodule

bind tmctl_timer16 tmctl_timer16_monitor #(.CTRL_A_ADR(CTRL_A_ADR), .CTRL_B_ADR(CTRL_B_ADR))
  u_mon (.clk_sys, .rst_b, .dat_addr, .dat_wr, .dat_rd, .dat_wdata, .dat_rdata,
  .compare_a_wdata, .compare_a_wr, .capture_pin, .count_q, .compare_a_value,
  .capture_flag, .overflow_flag);

//--- test/tb_tmctl_timer16.sv
// testbench: register access, clock select, capture and waveform mode checks
`timescale 1ns/10ps
module tb_tmctl_timer16;
  import tmctl_pkg::*;
  logic clk_sys, rst_b, dat_wr, dat_rd, compare_a_wr, capture_pin, ext_count_pin;
  logic capture_flag_clr, capture_flag, overflow_flag, count_down;
  logic [7:0] dat_addr, dat_wdata, dat_rdata;
  logic [15:0] compare_a_wdata, count_q, compare_a_value, capture_value, c0;
  int failures, n_checks;
  int divs[5] = '{1, 8, 64, 256, 1024};
  localparam logic [7:0] RA = TMCTL_T3_CTRL_A_ADR;
  localparam logic [7:0] RB = TMCTL_T3_CTRL_B_ADR;
  tmctl_timer16 #(.CTRL_A_ADR(RA), .CTRL_B_ADR(RB)) uut (.clk_sys, .rst_b, .dat_addr,
    .dat_wr, .dat_rd, .dat_wdata, .dat_rdata, .compare_a_wdata, .compare_a_wr, .capture_pin,
    .ext_count_pin, .capture_flag_clr, .count_q, .compare_a_value, .capture_value,
    .capture_flag, .overflow_flag, .count_down);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic step(int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    step();
    dat_addr = a;
    dat_wdata = d;
    dat_wr = 1'b1;
    step();
    dat_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    step();
    dat_addr = a;
    dat_rd = 1'b1;
    step();
    dat_rd = 1'b0;
    chk({8'h00, dat_rdata}, {8'h00, exp});
  endtask
  task automatic cmp(logic [15:0] v);
    step();
    compare_a_wdata = v;
    compare_a_wr = 1'b1;
    step();
    compare_a_wr = 1'b0;
  endtask
  // the shared clear drops both flags, so each flag test starts clean
  task automatic pulse_clr();
    step();
    capture_flag_clr = 1'b1;
    step();
    capture_flag_clr = 1'b0;
  endtask
  task automatic waitc(logic [15:0] v);
    for (int i = 0; i < 2000 && count_q !== v; i++) step();
    if (count_q !== v) begin
      failures++;
      close_out();
    end
  endtask
  task automatic cap(logic [7:0] b, logic pin, logic exp, logic filt);
    wr(RB, b);
    pulse_clr();
    capture_pin = pin;
    step(3);
    if (filt) chk({15'h0, capture_flag}, 16'h0000);
    step(5);
    chk({15'h0, capture_flag}, {15'h0, exp});
  endtask
  initial begin
    {dat_wr, dat_rd, compare_a_wr, capture_pin, ext_count_pin, capture_flag_clr} = 6'h00;
    dat_addr = 8'h00;
    dat_wdata = 8'h00;
    compare_a_wdata = 16'h0000;
    rst_b = 1'b0;
    step(12);
    rst_b = 1'b1;
    rd(RA, 8'h00);
    wr(RB, 8'hE0);
    rd(RB, 8'hC0);
    wr(TMCTL_T1_CTRL_B_IO + TMCTL_IO_DATA_OFS, 8'hFF);
    rd(TMCTL_T1_CTRL_B_IO + TMCTL_IO_DATA_OFS, 8'h00);
    rd(RB, 8'hC0);
    wr(RB, 8'h00);
    step(20);
    chk(count_q, 16'h0000);
    foreach (divs[i]) begin
      wr(RB, {5'h00, 3'(i + 1)});
      c0 = count_q;
      step(4 * divs[i]);
      chk(count_q, c0 + 16'h0004);
    end
    for (int k = 6; k < 8; k++) begin
      wr(RB, 8'(k));
      c0 = count_q;
      repeat (3) begin
        ext_count_pin = 1'b1;
        step(3);
        ext_count_pin = 1'b0;
        step(3);
      end
      chk(count_q, c0 + 16'h0003);
    end
    // a second reset brings the counter below every fixed TOP before the mode runs
    wr(RB, 8'h01);
    rst_b = 1'b0;
    step(2);
    rst_b = 1'b1;
    chk(count_q, 16'h0000);
    wr(RB, 8'h01);
    step(37);
    cap(8'h40, 1'b1, 1'b1, 1'b0);
    chk(capture_value, 16'h0027);
    cap(8'h40, 1'b0, 1'b0, 1'b0);
    cap(8'h00, 1'b1, 1'b0, 1'b0);
    cap(8'h00, 1'b0, 1'b1, 1'b0);
    cap(8'hC0, 1'b1, 1'b1, 1'b1);
    wr(RA, 8'h02);
    cap(8'h18, 1'b0, 1'b0, 1'b0);
    wr(RA, 8'h00);
    wr(RB, 8'h00);
    cmp(16'h1234);
    step();
    chk(compare_a_value, 16'h1234);
    foreach (divs[i]) if (i < 2) begin
      wr(RB, 8'(8'h08 + 8'h10 * i));
      cmp(16'(16'h0042 + i));
      step();
      chk(compare_a_value, 16'(16'h0042 + i));
    end
    // register B first, so the reserved mode is never passed through
    wr(RB, 8'h09);
    wr(RA, 8'h01);
    pulse_clr();
    waitc(16'h00FF);
    step();
    chk({15'h0, overflow_flag}, 16'h0001);
    chk(count_q, 16'h0000);
    wr(RB, 8'h01);
    pulse_clr();
    waitc(16'h00FF);
    chk({15'h0, overflow_flag}, 16'h0000);
    cmp(16'h0077);
    chk(compare_a_value, 16'h0043);
    chk({15'h0, count_down}, 16'h0001);
    waitc(16'h0000);
    step(2);
    chk({15'h0, overflow_flag}, 16'h0001);
    chk({15'h0, count_down}, 16'h0000);
    waitc(16'h00FF);
    step();
    chk(compare_a_value, 16'h0077);
    // mode 9 entered while counting down: compare and flag both wait for BOTTOM
    wr(RB, 8'h11);
    pulse_clr();
    cmp(16'h0030);
    chk(compare_a_value, 16'h0077);
    chk({15'h0, overflow_flag}, 16'h0000);
    waitc(16'h0000);
    step();
    chk(compare_a_value, 16'h0030);
    chk({15'h0, overflow_flag}, 16'h0001);
    close_out();
  end
endmodule
